// ===== logic/bus_fault_status_recorder.sv
// Local design decision: strobed register access.
`timescale 1ns/1ps

// Functional notes
// - 32-bit register captures precise data fault address
// - Address meaningful only while valid flag set
// - Precise error sets flag, captures address, valid
// - Status is 8-bit write-one-to-clear byte
// - Address alias for Secure non-debug access, zero otherwise
// - Status alias for Secure non-debug access, zero otherwise
// - Secure routing hides Non-secure views, ignores writes
// - Unprivileged access faults instead of completing
// - Address register accepts only word accesses
// - Status accepts byte/half/word with main extension
// - Lazy floating-point save error sets bit 5
// - Entry stacking error sets bit 4
// - Return unstacking error sets bit 3
// - Imprecise error sets bit 2, no address
// - Fetch error recorded only once instruction issues
// - Flags clear on warm reset, bit 6 zero
// - Address register content not reset
// - Shared store undefined while memmanage valid set
// - Shared store never leaks Secure addresses
// - One physical instance serves both Security states
// - Routing input: 0 Secure, 1 Non-secure
module bus_fault_status_recorder #(
    parameter bit MAIN_EXTENSION = 1'b1,
    parameter bit SHARED_ADDRESS_STORE = 1'b0
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic [1:0] bus_size_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic bus_priv_in,
    input wire logic bus_secure_in,
    input wire logic bus_debug_in,
    input wire logic fault_nonsecure_route_in,
    input wire logic memmanage_address_valid_in,
    input wire logic evt_valid_in,
    input wire logic [2:0] evt_cause_in,
    input wire logic [31:0] evt_addr_in,
    input wire logic insn_issue_in,
    input wire logic fetch_flush_in,
    output logic [31:0] bus_rdata_out,
    output logic bus_fault_out,
    output logic [7:0] status_out
);

    typedef struct packed {
        logic [7:0] status;
        logic [31:0] address;
        logic fetch_pending;
        logic [31:0] rdata;
        logic fault;
    } state_type;

    state_type st_q;
    state_type st_d;

    // Status hit: byte at the printed offset, or half/word at the word base.
    // Returns {hit, status in bits [15:8]}.
    function automatic logic [1:0] status_hit(input logic [31:0] addr, input logic [1:0] size,
                                              input logic [31:0] byte_addr,
                                              input logic [31:0] word_addr);
        logic [1:0] res;
        res = 2'h0;
        if (addr == byte_addr && size == fault_recorder_pkg::SIZE_BYTE && MAIN_EXTENSION) begin
            res = 2'h2;
        end else if (addr == word_addr && size == fault_recorder_pkg::SIZE_HALF
                     && MAIN_EXTENSION) begin
            res = 2'h3;
        end else if (addr == word_addr && size == fault_recorder_pkg::SIZE_WORD) begin
            res = 2'h3;
        end
        return res;
    endfunction

    logic [1:0] st_main;
    logic [1:0] st_alias;
    logic ad_main;
    logic ad_alias;
    logic mapped;
    logic allowed;
    logic visible;
    logic [7:0] wr_byte;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    logic [31:0] addr_view;

    // Decode and visibility; one instance, two views of it
    always_comb begin
        st_main = status_hit(bus_addr_in, bus_size_in, fault_recorder_pkg::STATUS_ADDR,
                             fault_recorder_pkg::STATUS_WORD_ADDR);
        st_alias = status_hit(bus_addr_in, bus_size_in,
                              fault_recorder_pkg::STATUS_NS_ALIAS_ADDR,
                              fault_recorder_pkg::STATUS_NS_ALIAS_WORD_ADDR);
        // Sub-word accesses to the address register are simply not decoded
        ad_main = (bus_addr_in == fault_recorder_pkg::ADDRESS_ADDR)
                  && (bus_size_in == fault_recorder_pkg::SIZE_WORD);
        ad_alias = (bus_addr_in == fault_recorder_pkg::ADDRESS_NS_ALIAS_ADDR)
                   && (bus_size_in == fault_recorder_pkg::SIZE_WORD);
        mapped = st_main[1] | st_alias[1] | ad_main | ad_alias;
        // The debugger counts as privileged
        allowed = bus_priv_in | bus_debug_in;
        if (st_main[1] | ad_main) begin
            // Non-secure callers see the Non-secure view here
            visible = bus_secure_in | fault_nonsecure_route_in;
        end else if (st_alias[1] | ad_alias) begin
            visible = bus_secure_in & ~bus_debug_in & fault_nonsecure_route_in;
        end else begin
            visible = 1'b0;
        end
        if (st_main[0] | st_alias[0]) begin
            wr_byte = bus_wdata_in[fault_recorder_pkg::STATUS_WORD_LSB +: 8];
        end else begin
            wr_byte = bus_wdata_in[7:0];
        end
        // Shared store reads zero while the memmanage address valid input is set
        if (SHARED_ADDRESS_STORE && memmanage_address_valid_in) begin
            addr_view = 32'h0000_0000;
        end else begin
            addr_view = st_q.address;
        end
    end

    // Next-state: events set, writes clear, set wins
    always_comb begin
        st_d = st_q;
        st_d.fault = 1'b0;
        st_d.rdata = 32'h0000_0000;
        set_mask = 8'h00;
        clr_mask = 8'h00;
        if (evt_valid_in) begin
            case (evt_cause_in)
                fault_recorder_pkg::CAUSE_PRECISE: begin
                    set_mask[fault_recorder_pkg::PRECISE_DATA_ERROR_BIT] = 1'b1;
                    set_mask[fault_recorder_pkg::ADDRESS_VALID_FLAG_BIT] = 1'b1;
                end
                fault_recorder_pkg::CAUSE_IMPRECISE: begin
                    set_mask[fault_recorder_pkg::IMPRECISE_DATA_ERROR_BIT] = 1'b1;
                end
                fault_recorder_pkg::CAUSE_UNSTACK: begin
                    set_mask[fault_recorder_pkg::RETURN_UNSTACKING_ERROR_BIT] = 1'b1;
                end
                fault_recorder_pkg::CAUSE_STACK: begin
                    set_mask[fault_recorder_pkg::ENTRY_STACKING_ERROR_BIT] = 1'b1;
                end
                fault_recorder_pkg::CAUSE_LAZY_FP: begin
                    set_mask[fault_recorder_pkg::LAZY_FP_SAVE_ERROR_BIT] = 1'b1;
                end
                fault_recorder_pkg::CAUSE_FETCH: begin
                    st_d.fetch_pending = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // A prefetch error waits until its instruction actually issues
        if (st_q.fetch_pending && insn_issue_in) begin
            set_mask[fault_recorder_pkg::FETCH_BUS_ERROR_BIT] = 1'b1;
            st_d.fetch_pending = 1'b0;
        end else if (st_q.fetch_pending && fetch_flush_in) begin
            st_d.fetch_pending = 1'b0;
        end
        // Register port; unprivileged hits fault and change nothing
        if ((bus_wr_in | bus_rd_in) && mapped && !allowed) begin
            st_d.fault = 1'b1;
        end else if (bus_wr_in && visible) begin
            if (st_main[1] | st_alias[1]) begin
                clr_mask = wr_byte & fault_recorder_pkg::STATUS_WRITABLE;
            end else begin
                st_d.address = bus_wdata_in;
            end
        end else if (bus_rd_in && visible) begin
            if (st_main[0] | st_alias[0]) begin
                st_d.rdata[fault_recorder_pkg::STATUS_WORD_LSB +: 8] = st_q.status;
            end else if (st_main[1] | st_alias[1]) begin
                st_d.rdata[7:0] = st_q.status;
            end else begin
                st_d.rdata = addr_view;
            end
        end
        st_d.status = ((st_q.status & ~clr_mask) | set_mask)
                      & fault_recorder_pkg::STATUS_WRITABLE;
        // Event capture after the write so a same-cycle fault address wins
        if (evt_valid_in && evt_cause_in == fault_recorder_pkg::CAUSE_PRECISE) begin
            st_d.address = evt_addr_in;
        end
        // Warm reset clears flags; the address store is left alone
        if (srst_in) begin
            st_d.status = fault_recorder_pkg::STATUS_RESET;
            st_d.fetch_pending = 1'b0;
            st_d.rdata = 32'h0000_0000;
            st_d.fault = 1'b0;
            st_d.address = st_q.address;
        end
    end

    // Single state register
    always_ff @(posedge mclk_in) begin
        st_q <= st_d;
    end

    assign bus_rdata_out = st_q.rdata;
    assign bus_fault_out = st_q.fault;
    assign status_out = st_q.status;

endmodule // bus_fault_status_recorder

// ===== logic/fault_recorder_pkg.sv
package fault_recorder_pkg;

    // Printed byte addresses of the two registers and their aliases
    localparam logic [31:0] STATUS_ADDR = 32'he000ed29;
    localparam logic [31:0] STATUS_WORD_ADDR = 32'he000ed28;
    localparam logic [31:0] ADDRESS_ADDR = 32'he000ed38;
    localparam logic [31:0] STATUS_NS_ALIAS_ADDR = 32'he002ed29;
    localparam logic [31:0] STATUS_NS_ALIAS_WORD_ADDR = 32'he002ed28;
    localparam logic [31:0] ADDRESS_NS_ALIAS_ADDR = 32'he002ed38;

    // Access sizes on the register port
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;

    // Status field positions
    localparam int FETCH_BUS_ERROR_BIT = 0;
    localparam int PRECISE_DATA_ERROR_BIT = 1;
    localparam int IMPRECISE_DATA_ERROR_BIT = 2;
    localparam int RETURN_UNSTACKING_ERROR_BIT = 3;
    localparam int ENTRY_STACKING_ERROR_BIT = 4;
    localparam int LAZY_FP_SAVE_ERROR_BIT = 5;
    localparam int RESERVED_BIT = 6;
    localparam int ADDRESS_VALID_FLAG_BIT = 7;

    // Status byte sits in bits [15:8] of the combined fault status word
    localparam int STATUS_WORD_LSB = 8;
    localparam int STATUS_WIDTH = 8;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [7:0] STATUS_WRITABLE = 8'hbf;

    // Cause tags presented with an error event
    localparam logic [2:0] CAUSE_PRECISE = 3'h1;
    localparam logic [2:0] CAUSE_IMPRECISE = 3'h2;
    localparam logic [2:0] CAUSE_UNSTACK = 3'h3;
    localparam logic [2:0] CAUSE_STACK = 3'h4;
    localparam logic [2:0] CAUSE_LAZY_FP = 3'h5;
    localparam logic [2:0] CAUSE_FETCH = 3'h6;

endpackage

// ===== tb/fault_core_model.sv
`timescale 1ns/1ps
module fault_core_model (
    input wire logic clk_in,
    output logic evt_valid_out,
    output logic [2:0] evt_cause_out,
    output logic [31:0] evt_addr_out,
    output logic insn_issue_out,
    output logic fetch_flush_out
);
    // Quiet at start; no event pending
    initial begin
        evt_valid_out = 1'b0;
        evt_cause_out = 3'h0;
        evt_addr_out = 32'h0;
        insn_issue_out = 1'b0;
        fetch_flush_out = 1'b0;
    end
    // One-cycle tagged pulse; address scrambled afterwards so a stale copy never matches
    task automatic raise(input logic [2:0] cause, input logic [31:0] addr);
        evt_valid_out <= 1'b1;
        evt_cause_out <= cause;
        evt_addr_out <= addr;
        @(posedge clk_in);
        evt_valid_out <= 1'b0;
        evt_cause_out <= 3'h0;
        evt_addr_out <= ~addr;
    endtask
    // Issue or discard of the faulting prefetched instruction
    task automatic pulse(input logic flush);
        insn_issue_out <= !flush;
        fetch_flush_out <= flush;
        @(posedge clk_in);
        insn_issue_out <= 1'b0;
        fetch_flush_out <= 1'b0;
    endtask
endmodule // fault_core_model

// ===== tb/fault_recorder_chk.sv
`timescale 1ns/1ps
module fault_recorder_chk (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic [1:0] bus_size_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic bus_priv_in,
    input wire logic bus_secure_in,
    input wire logic bus_debug_in,
    input wire logic evt_valid_in,
    input wire logic [2:0] evt_cause_in,
    input wire logic insn_issue_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic bus_fault_out,
    input wire logic [7:0] status_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    // Building blocks: an event of one cause, a byte access to the status register
    sequence ev_s(logic [2:0] c); evt_valid_in && evt_cause_in == c; endsequence
    sequence sb_s; bus_addr_in == fault_recorder_pkg::STATUS_ADDR
        && bus_size_in == fault_recorder_pkg::SIZE_BYTE; endsequence
    sequence clr_s; bus_wr_in && bus_priv_in && bus_secure_in && !bus_debug_in
        && bus_wdata_in[7:0] == 8'hff && !evt_valid_in && !insn_issue_in ##0 sb_s; endsequence
    precise_sets_a: assert property (ev_s(3'h1) |=> status_out[7] && status_out[1])
        else $error("precise flags missing");
    imprecise_sets_a: assert property (ev_s(3'h2) |=> status_out[2])
        else $error("imprecise flag missing");
    unstack_sets_a: assert property (ev_s(3'h3) |=> status_out[3])
        else $error("unstack flag missing");
    stack_sets_a: assert property (ev_s(3'h4) |=> status_out[4])
        else $error("stack flag missing");
    lazy_sets_a: assert property (ev_s(3'h5) |=> status_out[5])
        else $error("lazy save flag missing");
    fetch_on_issue_a: assert property ($rose(status_out[0]) |-> $past(insn_issue_in))
        else $error("fetch flag without issue");
    unpriv_faults_a: assert property ((bus_wr_in || bus_rd_in) && !bus_priv_in && !bus_debug_in
        ##0 sb_s |=> bus_fault_out && bus_rdata_out == 32'h0)
        else $error("unprivileged access not faulted");
    w1c_clears_a: assert property (clr_s |=> status_out == 8'h00)
        else $error("status not cleared");
    flag_sticky_a: assert property ($fell(status_out[2]) |-> $past(bus_wr_in))
        else $error("flag dropped without write");
    reserved_zero_a: assert property (status_out[6] == 1'b0)
        else $error("reserved bit set");
endmodule // fault_recorder_chk
bind bus_fault_status_recorder fault_recorder_chk i_chk (.mclk_in(mclk_in), .srst_in(srst_in),
    .bus_addr_in(bus_addr_in), .bus_wdata_in(bus_wdata_in), .bus_size_in(bus_size_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_priv_in(bus_priv_in),
    .bus_secure_in(bus_secure_in), .bus_debug_in(bus_debug_in), .evt_valid_in(evt_valid_in),
    .evt_cause_in(evt_cause_in), .insn_issue_in(insn_issue_in), .bus_rdata_out(bus_rdata_out),
    .bus_fault_out(bus_fault_out), .status_out(status_out));

// ===== tb/test_bus_fault_status_recorder.sv
`timescale 1ns/1ps
module test_bus_fault_status_recorder;
    logic mclk_in = 1'b0, srst_in = 1'b1, wr = 1'b0, rd = 1'b0, priv = 1'b1, sec = 1'b1;
    logic dbg = 1'b0, route = 1'b1, ev, iss, fl, fault;
    logic [31:0] ad = 32'h0, wd = 32'h0, rdata, ea;
    logic [1:0] sz = 2'h0;
    logic [2:0] ca;
    logic [7:0] st;
    int error_cnt = 0, n_tests = 0;
    bus_fault_status_recorder i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .bus_addr_in(ad),
        .bus_wdata_in(wd), .bus_size_in(sz), .bus_wr_in(wr), .bus_rd_in(rd), .bus_priv_in(priv),
        .bus_secure_in(sec), .bus_debug_in(dbg), .fault_nonsecure_route_in(route),
        .memmanage_address_valid_in(1'b0), .evt_valid_in(ev), .evt_cause_in(ca),
        .evt_addr_in(ea), .insn_issue_in(iss), .fetch_flush_in(fl), .bus_rdata_out(rdata),
        .bus_fault_out(fault), .status_out(st));
    fault_core_model i_core (.clk_in(mclk_in), .evt_valid_out(ev), .evt_cause_out(ca),
        .evt_addr_out(ea), .insn_issue_out(iss), .fetch_flush_out(fl));
    // 50 ns clock
    initial begin
        forever #25 mclk_in = ~mclk_in;
    end
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle strobe; answer sampled just after the taking edge has landed
    task automatic bus(input logic w, input logic [31:0] a, input logic [1:0] s, input logic [31:0] d);
        wr <= w;
        rd <= !w;
        ad <= a;
        sz <= s;
        wd <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
        rd <= 1'b0;
        #1;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [1:0] s, input logic [31:0] e, input logic f);
        bus(1'b0, a, s, 32'h0);
        check("rdata", e, rdata);
        check("fault", {31'h0, f}, {31'h0, fault});
    endtask
    task automatic rst_b(input logic [31:0] e);
        rchk(fault_recorder_pkg::STATUS_ADDR, fault_recorder_pkg::SIZE_BYTE, e, 1'b0);
    endtask
    task automatic wst(input logic [31:0] d);
        bus(1'b1, fault_recorder_pkg::STATUS_ADDR, fault_recorder_pkg::SIZE_BYTE, d);
    endtask
    // Every non-address cause except fetch sets its own bit and clears by write-one
    task automatic t_causes;
        for (int c = 2; c <= 5; c++) begin
            i_core.raise(3'(c), 32'h0);
            rst_b(32'h1 << c);
            wst(32'hff);
        end
        rst_b(32'h0);
    endtask
    task automatic t_precise;
        i_core.raise(fault_recorder_pkg::CAUSE_PRECISE, 32'h2000_1234);
        rst_b(32'h82);
        rchk(fault_recorder_pkg::ADDRESS_ADDR, 2'h2, 32'h2000_1234, 1'b0);
        rchk(fault_recorder_pkg::ADDRESS_ADDR, 2'h0, 32'h0, 1'b0);
        rchk(fault_recorder_pkg::STATUS_WORD_ADDR, 2'h1, 32'h8200, 1'b0);
        wst(32'h02);
        rst_b(32'h80);
    endtask
    // Fetch error counts only once issued; a discarded prefetch leaves no trace
    task automatic t_fetch;
        i_core.raise(fault_recorder_pkg::CAUSE_FETCH, 32'h0);
        rst_b(32'h80);
        i_core.pulse(1'b0);
        rst_b(32'h81);
        wst(32'h01);
        i_core.raise(fault_recorder_pkg::CAUSE_FETCH, 32'h0);
        i_core.pulse(1'b1);
        i_core.pulse(1'b0);
        rst_b(32'h80);
    endtask
    task automatic t_secure;
        route <= 1'b0;
        sec <= 1'b0;
        rst_b(32'h0);
        wst(32'hff);
        sec <= 1'b1;
        rst_b(32'h80);
        rchk(fault_recorder_pkg::STATUS_NS_ALIAS_ADDR, 2'h0, 32'h0, 1'b0);
        rchk(fault_recorder_pkg::ADDRESS_NS_ALIAS_ADDR, 2'h2, 32'h0, 1'b0);
        route <= 1'b1;
        rchk(fault_recorder_pkg::STATUS_NS_ALIAS_ADDR, 2'h0, 32'h80, 1'b0);
        rchk(fault_recorder_pkg::ADDRESS_NS_ALIAS_ADDR, 2'h2, 32'h2000_1234, 1'b0);
        dbg <= 1'b1;
        rchk(fault_recorder_pkg::ADDRESS_NS_ALIAS_ADDR, 2'h2, 32'h0, 1'b0);
        dbg <= 1'b0;
        sec <= 1'b0;
        rchk(fault_recorder_pkg::STATUS_NS_ALIAS_ADDR, 2'h0, 32'h0, 1'b0);
        rst_b(32'h80);
        sec <= 1'b1;
    endtask
    // Unprivileged access faults and has no effect; unmapped reads zero quietly
    task automatic t_priv;
        priv <= 1'b0;
        rchk(fault_recorder_pkg::STATUS_ADDR, 2'h0, 32'h0, 1'b1);
        wst(32'hff);
        priv <= 1'b1;
        rst_b(32'h80);
        rchk(32'he000ed30, 2'h2, 32'h0, 1'b0);
        fork
            i_core.raise(fault_recorder_pkg::CAUSE_IMPRECISE, 32'h0);
            wst(32'hff);
        join
        rst_b(32'h04);
    endtask
    // Warm reset in mid-run clears every flag but keeps the captured address
    task automatic t_reset;
        srst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        #1;
        rst_b(32'h0);
        rchk(fault_recorder_pkg::ADDRESS_ADDR, 2'h2, 32'h2000_1234, 1'b0);
    endtask
    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Watchdog: the whole sequence needs well under 4000 cycles
    initial begin
        #200000;
        error_cnt++;
        give_verdict;
    end
    initial begin
        repeat (16) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        rst_b(32'h0);
        t_causes;
        t_precise;
        t_fetch;
        t_secure;
        t_priv;
        t_reset;
        give_verdict;
    end
endmodule // test_bus_fault_status_recorder
